// >>> core/term_ports.v
// control, status and printer ports with host line gating, AHB-Lite slave
//
// The AHB-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "term_port_regs.vh"
module term_ports (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output wire [31:0] hrdata,
  // interrupt
  output wire irq,
  // modem control outputs
  output wire host_terminal_ready_out,
  output wire host_speed_select_out,
  output wire carrier_control_out,
  output wire loop_or_modem_select,
  // display control outputs
  output wire wide_column_select,
  output wire whole_screen_inverse,
  // status inputs
  input wire host_dsr_in,
  input wire host_speed_indicator_in,
  input wire host_clear_to_send_in,
  input wire alignment_test_input,
  input wire [3:0] scan_line,
  input wire printer_busy,
  input wire printer_ack,
  // printer data
  output wire [7:0] printer_data_lines,
  // host serial gating
  input wire host_serial_tx,
  output wire host_serial_rx,
  output wire host_cts_to_uart,
  input wire cts_control_route,
  output wire carrier_control_route,
  output wire comm_tx,
  input wire comm_rx,
  output wire loop_tx,
  input wire loop_rx
);

  // ------------------------------------------------------------
  // bus state
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_WRITE = 2'd1;
  localparam ST_RWAIT = 2'd2;
  localparam ST_RDONE = 2'd3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [5:0] addr_q;
  reg [31:0] rdata_q;
  reg [31:0] rdata_d;

  // ------------------------------------------------------------
  // port registers
  // ------------------------------------------------------------
  reg [7:0] control_q;
  reg [7:0] printer_q;
  reg [`EVT_W-1:0] mask_q;
  reg ack_seen_q;
  reg ack_prev_q;
  reg dsr_prev_q;
  reg cts_prev_q;
  reg raster_prev_q;
  reg ready_prev_q;

  wire take = hsel && hready && htrans[1];
  wire wr_now = (state_q == ST_WRITE);
  wire wr_control = wr_now && (addr_q == `OFS_CONTROL);
  wire wr_printer = wr_now && (addr_q == `OFS_PRINTER);
  wire wr_int_status = wr_now && (addr_q == `OFS_INT_STATUS);
  wire wr_int_mask = wr_now && (addr_q == `OFS_INT_MASK);

  wire last_raster = (scan_line == `LAST_RASTER); // R10
  wire not_busy = ~printer_busy; // R11
  wire ack_rise = printer_ack && !ack_prev_q;

  wire [`EVT_W-1:0] flags;
  wire [`EVT_W-1:0] events;
  wire [7:0] status_word;

  // ------------------------------------------------------------
  // status input port
  // ------------------------------------------------------------
  // bit 3 is unconnected and reads zero
  assign status_word[`STS_DSR] = host_dsr_in; // R07
  assign status_word[`STS_SPEED_IND] = host_speed_indicator_in; // R08
  assign status_word[`STS_CTS] = host_clear_to_send_in; // R09
  assign status_word[3] = 1'b0; // R15
  assign status_word[`STS_ALIGN] = alignment_test_input;
  assign status_word[`STS_LAST_RASTER] = last_raster; // R10
  assign status_word[`STS_NOT_BUSY] = not_busy; // R11
  assign status_word[`STS_ACK] = ack_seen_q; // R12

  // ------------------------------------------------------------
  // bus control
  // ------------------------------------------------------------
  // reads take one wait state so a read right after a write sees it
  always @* begin
    state_d = ST_IDLE;
    case (state_q)
      ST_IDLE,
      ST_WRITE,
      ST_RDONE: begin
        if (take) begin
          state_d = hwrite ? ST_WRITE : ST_RWAIT;
        end else begin
          state_d = ST_IDLE;
        end
      end
      ST_RWAIT: begin
        state_d = ST_RDONE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @* begin
    rdata_d = 32'h00000000;
    case (addr_q)
      `OFS_CONTROL: begin
        rdata_d = {24'h000000, control_q};
      end
      `OFS_STATUS: begin
        rdata_d = {24'h000000, status_word};
      end
      `OFS_PRINTER: begin
        rdata_d = {24'h000000, printer_q};
      end
      `OFS_INT_STATUS: begin
        rdata_d = {27'h0000000, flags};
      end
      `OFS_INT_MASK: begin
        rdata_d = {27'h0000000, mask_q};
      end
      default: begin
        rdata_d = 32'h00000000;
      end
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      addr_q <= 6'h00;
      rdata_q <= 32'h00000000;
    end else begin
      state_q <= state_d;
      if (take) begin
        addr_q <= haddr[5:0];
      end
      if (state_q == ST_RWAIT) begin
        rdata_q <= rdata_d;
      end
    end
  end

  assign hreadyout = (state_q != ST_RWAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_q;

  // ------------------------------------------------------------
  // output port registers
  // ------------------------------------------------------------
  // values hold until software writes again
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      control_q <= `RST_CONTROL;
      printer_q <= `RST_PRINTER;
      mask_q <= `RST_INT_MASK;
    end else begin
      if (wr_control) begin
        control_q <= hwdata[7:0]; // R15
      end
      if (wr_printer) begin
        printer_q <= hwdata[7:0]; // R15
      end
      if (wr_int_mask) begin
        mask_q <= hwdata[`EVT_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------
  // acknowledge latch
  // ------------------------------------------------------------
  // a pulse shorter than a software poll is held until the next byte
  // is written; a pulse in that very cycle still sets the latch
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_seen_q <= 1'b0;
      ack_prev_q <= 1'b0;
    end else begin
      ack_prev_q <= printer_ack;
      if (printer_ack) begin
        ack_seen_q <= 1'b1; // R12
      end else if (wr_printer) begin
        ack_seen_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // interrupt events
  // ------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      dsr_prev_q <= 1'b0;
      cts_prev_q <= 1'b0;
      raster_prev_q <= 1'b0;
      ready_prev_q <= 1'b0;
    end else begin
      dsr_prev_q <= host_dsr_in;
      cts_prev_q <= host_clear_to_send_in;
      raster_prev_q <= last_raster;
      ready_prev_q <= not_busy;
    end
  end

  assign events[`EVT_ACK] = ack_rise;
  assign events[`EVT_DSR] = host_dsr_in ^ dsr_prev_q;
  assign events[`EVT_CTS] = host_clear_to_send_in ^ cts_prev_q;
  assign events[`EVT_RASTER] = last_raster && !raster_prev_q;
  assign events[`EVT_READY] = not_busy && !ready_prev_q;

  event_flags #(
    .WIDTH(`EVT_W)
  ) u_flags (
    .clk(clk),
    .reset_n(reset_n),
    .event_in(events),
    .clear_in(wr_int_status ? hwdata[`EVT_W-1:0] : {`EVT_W{1'b0}}),
    .mask_in(mask_q),
    .flags(flags),
    .irq(irq)
  );

  // ------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------
  // standby bit 2 and bit 7 are stored but drive nothing
  assign host_terminal_ready_out = control_q[`CTL_TERM_READY]; // R01
  assign host_speed_select_out = control_q[`CTL_SPEED_SEL]; // R02
  assign carrier_control_out = control_q[`CTL_CARRIER]; // R03
  assign loop_or_modem_select = control_q[`CTL_LOOP_SEL]; // R04
  assign wide_column_select = control_q[`CTL_WIDE]; // R05
  assign whole_screen_inverse = control_q[`CTL_INVERSE]; // R06
  assign printer_data_lines = printer_q; // R13

  // ------------------------------------------------------------
  // host line gating
  // ------------------------------------------------------------
  // the unselected transmitter idles at mark so the far end sees no data
  assign comm_tx = loop_or_modem_select ? 1'b1 : host_serial_tx; // R04 R14
  assign loop_tx = loop_or_modem_select ? host_serial_tx : 1'b1; // R04 R14
  assign host_serial_rx = loop_or_modem_select ? loop_rx : comm_rx; // R14
  // the loop has no handshake, so the printer port's cts stands in
  assign host_cts_to_uart = loop_or_modem_select ? cts_control_route
                                                 : host_clear_to_send_in; // R14
  // carrier detect only follows the control bit while the modem is chosen
  assign carrier_control_route = carrier_control_out && !loop_or_modem_select; // R03 R14

endmodule // term_ports

// >>> core/term_port_regs.vh
// register map and constants of the terminal control and status ports
//
// Overview of operation
// R01: control bit 0 drives the host terminal-ready line high while set.
// R02: control bit 1 switches the host speed-select output on while set.
// R03: control bit 3 feeds the circuit making the carrier-detect line.
// R04: control bit 4 routes host serial to modem when low, loop when high.
// R05: control bit 5 high selects 132 columns, low selects 80.
// R06: control bit 6 high shows the whole screen inverted.
// R07: status bit 0 reads high while modem data-set-ready is on.
// R08: status bit 1 reads high while host speed indicator is on.
// R09: status bit 2 reads high while host clear-to-send is on.
// R10: status bit 5 reads high during the last raster, scan line 10.
// R11: status bit 6 shows the inverse of printer busy.
// R12: status bit 7 shows a latched printer acknowledge, never missing pulses.
// R13: printer data bits 0 to 7 drive printer data lines 0 to 7.
// R14: gating switches host lines by select bit, carrier bit, printer cts.
// R15: outputs hold until rewritten; spare outputs inert; spare inputs ignored.
`ifndef TERM_PORT_REGS_VH
`define TERM_PORT_REGS_VH

// byte offsets on the bus
`define OFS_CONTROL 6'h00
`define OFS_STATUS 6'h04
`define OFS_PRINTER 6'h08
`define OFS_INT_STATUS 6'h0c
`define OFS_INT_MASK 6'h10

// reset values
`define RST_CONTROL 8'h00
`define RST_PRINTER 8'h00
`define RST_INT_MASK 5'h00

// control output port fields
`define CTL_TERM_READY 0
`define CTL_SPEED_SEL 1
`define CTL_STANDBY 2
`define CTL_CARRIER 3
`define CTL_LOOP_SEL 4
`define CTL_WIDE 5
`define CTL_INVERSE 6

// status input port fields
`define STS_DSR 0
`define STS_SPEED_IND 1
`define STS_CTS 2
`define STS_ALIGN 4
`define STS_LAST_RASTER 5
`define STS_NOT_BUSY 6
`define STS_ACK 7

// interrupt event fields
`define EVT_W 5
`define EVT_ACK 0
`define EVT_DSR 1
`define EVT_CTS 2
`define EVT_RASTER 3
`define EVT_READY 4

// raster index of the last scan line in a character row
`define LAST_RASTER 4'ha

`endif

// >>> core/event_flags.v
// sticky event flags with write-one-to-clear and mask
`timescale 1ns/1ps
module event_flags #(
  parameter WIDTH = 5
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // events and software clear
  input wire [WIDTH-1:0] event_in,
  input wire [WIDTH-1:0] clear_in,
  input wire [WIDTH-1:0] mask_in,
  // state
  output wire [WIDTH-1:0] flags,
  output wire irq
);

  reg [WIDTH-1:0] flag_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
      // set beats clear so an event in the clearing cycle survives
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          flag_q[i] <= 1'b0;
        end else if (event_in[i]) begin
          flag_q[i] <= 1'b1;
        end else if (clear_in[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign flags = flag_q;
  assign irq = |(flag_q & mask_in);

endmodule // event_flags

// >>> testbench/term_ports_checker.sv
// assertion checker for the terminal port block
`timescale 1ns/1ps
module term_ports_checker (
  // watched ports
  input wire clk,
  input wire reset_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire host_terminal_ready_out,
  input wire host_speed_select_out,
  input wire carrier_control_out,
  input wire loop_or_modem_select,
  input wire wide_column_select,
  input wire whole_screen_inverse,
  input wire [7:0] printer_data_lines,
  input wire host_serial_tx,
  input wire host_serial_rx,
  input wire host_cts_to_uart,
  input wire host_clear_to_send_in,
  input wire cts_control_route,
  input wire carrier_control_route,
  input wire comm_tx,
  input wire comm_rx,
  input wire loop_tx,
  input wire loop_rx
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire sel = loop_or_modem_select;
  wire tk = hsel && hready && htrans[1];
  sequence wr_at(logic [5:0] a);
    tk && hwrite && haddr[5:0] == a ##1 1'b1;
  endsequence
  sequence rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_read_one_wait: assert property (tk && !hwrite |=> rd_wait) else $error("read wait wrong");
  a_ctl_out: assert property (wr_at(6'h00) |=> {whole_screen_inverse, wide_column_select, sel,
    carrier_control_out, host_speed_select_out, host_terminal_ready_out} ==
    {$past(hwdata[6:3]), $past(hwdata[1:0])}) else $error("control lines differ");
  a_prn_out: assert property (wr_at(6'h08) |=> printer_data_lines == $past(hwdata[7:0]))
    else $error("printer lines differ");
  a_prn_hold: assert property ($changed(printer_data_lines) |->
    $past(tk && hwrite && haddr[5:0] == 6'h08, 2)) else $error("printer lines moved");
  a_ctl_hold: assert property ($changed(whole_screen_inverse) |->
    $past(tk && hwrite && haddr[5:0] == 6'h00, 2)) else $error("inverse moved");
  a_modem_route: assert property (!sel |-> comm_tx == host_serial_tx && loop_tx &&
    host_serial_rx == comm_rx && host_cts_to_uart == host_clear_to_send_in)
    else $error("modem routing wrong");
  a_loop_route: assert property (sel |-> loop_tx == host_serial_tx && comm_tx &&
    host_serial_rx == loop_rx && host_cts_to_uart == cts_control_route)
    else $error("loop routing wrong");
  a_carrier_gate: assert property (carrier_control_route == (!sel && carrier_control_out))
    else $error("carrier route wrong");
endmodule // term_ports_checker

bind term_ports term_ports_checker chk (.*);

// >>> testbench/line_partner.sv
// far-side model: modem lines, current loop and printer
`timescale 1ns/1ps
module line_partner (
  // bench commands: ack request, busy, cts, speed, dsr
  input wire clk,
  input wire [4:0] cmd,
  // line side
  input wire comm_tx,
  input wire loop_tx,
  output wire host_dsr_in,
  output wire host_speed_indicator_in,
  output wire host_clear_to_send_in,
  output wire printer_busy,
  output wire printer_ack,
  output wire comm_rx,
  output wire loop_rx,
  output wire cts_control_route
);
  reg ack_q;
  always @(posedge clk) begin
    ack_q <= cmd[4];
  end
  assign {printer_busy, host_clear_to_send_in, host_speed_indicator_in, host_dsr_in} = cmd[3:0];
  // one-cycle ack, the shortest the latch must not miss
  assign printer_ack = cmd[4] & ~ack_q;
  assign comm_rx = comm_tx;
  // loop inverts so the two routes are told apart
  assign loop_rx = ~loop_tx;
  assign cts_control_route = ~host_clear_to_send_in;
endmodule // line_partner

// >>> testbench/tb_top.sv
// self-checking bench for the terminal port block
`timescale 1ns/1ps
module tb_top;
  reg clk, reset_n, hsel, hwrite, host_serial_tx, alignment_test_input;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [3:0] scan_line;
  reg [4:0] cmd;
  reg [31:0] haddr, hwdata, rv;
  wire hreadyout, hresp, irq, host_terminal_ready_out, host_speed_select_out, carrier_control_out;
  wire loop_or_modem_select, wide_column_select, whole_screen_inverse, host_serial_rx;
  wire host_cts_to_uart, carrier_control_route, comm_tx, comm_rx, loop_tx, loop_rx;
  wire host_dsr_in, host_speed_indicator_in, host_clear_to_send_in, printer_busy, printer_ack;
  wire cts_control_route;
  wire [31:0] hrdata;
  wire [7:0] printer_data_lines;
  wire hready = hreadyout;
  integer err_count, samples_checked, i;
  term_ports dut (.*);
  line_partner lp (.*);
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  // bounded wait for hready high at a rising edge
  // hready is looked at mid-cycle, where it has settled, not in the edge's own time step
  task rdy;
    integer n;
    begin
      n = 0;
      @(negedge clk);
      while (hready !== 1'h1 && n < 20) begin
        n = n + 1;
        @(negedge clk);
      end
      if (n == 20) begin
        err_count = err_count + 1;
        finish_test;
      end
      @(posedge clk);
    end
  endtask
  task ahb(input w, input [5:0] a, input [31:0] d);
    begin
      htrans <= 2'h2;
      haddr <= {26'h0, a};
      hwrite <= w;
      rdy;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      rv = hrdata;
    end
  endtask
  task st(input [4:0] c, input [3:0] s, input a, input [7:0] e);
    begin
      cmd <= c;
      scan_line <= s;
      alignment_test_input <= a;
      repeat (2) @(posedge clk);
      ahb(1'h0, 6'h04, 32'h0);
      chk("status", rv, {24'h0, e});
    end
  endtask
  initial begin
    err_count = 0;
    samples_checked = 0;
    {hwrite, host_serial_tx, alignment_test_input, reset_n} = 4'h0;
    hsel = 1'h1;
    htrans = 2'h0;
    hsize = 3'h2;
    scan_line = 4'h0;
    cmd = 5'h00;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (2) @(posedge clk);
    reset_n <= 1'h1;
    ahb(1'h0, 6'h00, 32'h0);
    chk("ctl reset", rv, 32'h0);
    chk("hresp", hresp, 32'h0);
    for (i = 0; i < 8; i = i + 1) begin
      ahb(1'h1, 6'h00, 32'h1 << i);
      @(posedge clk);
      chk("ctl out", {25'h0, whole_screen_inverse, wide_column_select, loop_or_modem_select,
        carrier_control_out, 1'h0, host_speed_select_out, host_terminal_ready_out},
        (32'h1 << i) & 32'h7b);
      chk("route", {comm_tx, loop_tx, host_serial_rx, host_cts_to_uart, carrier_control_route},
        i == 4 ? 32'h16 : (i == 3 ? 32'h09 : 32'h08));
      ahb(1'h0, 6'h00, 32'h0);
      chk("ctl read", rv, 32'h1 << i);
    end
    ahb(1'h1, 6'h08, 32'ha5);
    @(posedge clk);
    chk("printer", printer_data_lines, 32'ha5);
    st(5'h0d, 4'ha, 1'h1, 8'h35);
    st(5'h02, 4'h9, 1'h0, 8'h42);
    ahb(1'h1, 6'h0c, 32'h1f);
    st(5'h10, 4'h9, 1'h0, 8'hc0);
    ahb(1'h0, 6'h0c, 32'h0);
    chk("events", rv, 32'h1);
    chk("irq masked", irq, 32'h0);
    ahb(1'h1, 6'h10, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq set", irq, 32'h1);
    ahb(1'h1, 6'h0c, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq clear", irq, 32'h0);
    // printer write releases the ack latch; status stays read-only
    ahb(1'h1, 6'h08, 32'h0);
    ahb(1'h1, 6'h04, 32'hff);
    ahb(1'h0, 6'h04, 32'h0);
    chk("ack release", rv, 32'h40);
    ahb(1'h0, 6'h3c, 32'h0);
    chk("unmapped", rv, 32'h0);
    finish_test;
  end
endmodule // tb_top
